// ---- hw/cbt_pkg.sv ----
package cbt_pkg;

  localparam int CBT_ADDR_W = 8;
  localparam int CBT_DATA_W = 32;
  localparam int CBT_BYTE_W = 8;
  localparam int CBT_NUM_BUF = 2;

  // Byte address of the control word on the register bus
  localparam logic [7:0] CBT_CTRL_OFFSET = 8'h00;
  localparam int CBT_WORD_LSB = 2;

  // Which byte lane controls which buffer
  localparam int CBT_BUF_M = 0;
  localparam int CBT_BUF_N = 1;

  // Field positions inside one control byte
  localparam int CBT_BIT_DIR = 7;
  localparam int CBT_BIT_ABT = 6;
  localparam int CBT_BIT_LARB = 5;
  localparam int CBT_BIT_ERR = 4;
  localparam int CBT_BIT_REQ = 3;
  localparam int CBT_BIT_RTREN = 2;

  localparam logic [7:0] CBT_CTL_RESET = 8'h00;
  localparam logic [15:0] CBT_UPPER_ZERO = 16'h0000;
  localparam logic [31:0] CBT_RDATA_RESET = 32'h0000_0000;

  localparam logic [1:0] CBT_RESP_OKAY = 2'h0;
  localparam logic [1:0] CBT_RESP_SLVERR = 2'h2;

  // Reports from the protocol engine for one buffer, one-cycle pulses
  typedef struct packed {
    logic tx_done;
    logic tx_aborted;
    logic arb_lost;
    logic bus_error;
    logic rtr_received;
  } cbt_event_type;

  // Commands to the protocol engine for one buffer, levels
  typedef struct packed {
    logic transmit_request;
    logic abort_request;
    logic receive_mode;
  } cbt_tx_type;

endpackage

// ---- hw/cbt_buffer_ctl.sv ----
`timescale 1ns/1ps
module cbt_buffer_ctl
  import cbt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire cbt_event_type engine_event,
  output logic [7:0] ctl_byte,
  output cbt_tx_type tx
);

  logic buffer_direction_select, next_buffer_direction_select;
  logic message_aborted_flag, next_message_aborted_flag;
  logic arbitration_lost_flag, next_arbitration_lost_flag;
  logic transmit_bus_error_flag, next_transmit_bus_error_flag;
  logic send_request, next_send_request;
  logic auto_remote_reply_enable, next_auto_remote_reply_enable;
  logic abort_pending, next_abort_pending;
  logic sw_send, sw_abort, rtr_send, new_req, finished;

  always_comb begin
    sw_send = wr_en & wr_data[CBT_BIT_REQ] & ~send_request;   // see R6
    sw_abort = wr_en & ~wr_data[CBT_BIT_REQ] & send_request;  // see R8
    // Remote request is ignored while a send is already pending
    rtr_send = engine_event.rtr_received & auto_remote_reply_enable &
               ~send_request;  // see R9, see R10
    new_req = sw_send | rtr_send;
    finished = send_request &
               (engine_event.tx_done | engine_event.tx_aborted);
    next_buffer_direction_select = wr_en ? wr_data[CBT_BIT_DIR] :
                                   buffer_direction_select;
    next_auto_remote_reply_enable = wr_en ? wr_data[CBT_BIT_RTREN] :
                                    auto_remote_reply_enable;
    next_send_request = send_request;
    if (finished) begin
      next_send_request = 1'b0;  // see R7
    end else if (new_req) begin
      next_send_request = 1'b1;  // see R6, see R9
    end
    // Abort stays asserted until the engine closes the attempt
    next_abort_pending = abort_pending;
    if (finished | new_req) begin
      next_abort_pending = 1'b0;
    end else if (sw_abort) begin
      next_abort_pending = 1'b1;  // see R8
    end
    // Hardware set wins over the clear done by a new request
    next_message_aborted_flag = (message_aborted_flag &
        ~(new_req | (send_request & engine_event.tx_done))) |
        (send_request & engine_event.tx_aborted);  // see R3, see R11
    next_arbitration_lost_flag = (arbitration_lost_flag & ~new_req) |
        (send_request & engine_event.arb_lost);  // see R4, see R11
    next_transmit_bus_error_flag = (transmit_bus_error_flag & ~new_req) |
        (send_request & engine_event.bus_error);  // see R5, see R11
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      buffer_direction_select <= CBT_CTL_RESET[CBT_BIT_DIR];
      message_aborted_flag <= CBT_CTL_RESET[CBT_BIT_ABT];
      arbitration_lost_flag <= CBT_CTL_RESET[CBT_BIT_LARB];
      transmit_bus_error_flag <= CBT_CTL_RESET[CBT_BIT_ERR];
      send_request <= CBT_CTL_RESET[CBT_BIT_REQ];
      auto_remote_reply_enable <= CBT_CTL_RESET[CBT_BIT_RTREN];
      abort_pending <= 1'b0;
    end else begin
      buffer_direction_select <= next_buffer_direction_select;
      message_aborted_flag <= next_message_aborted_flag;
      arbitration_lost_flag <= next_arbitration_lost_flag;
      transmit_bus_error_flag <= next_transmit_bus_error_flag;
      send_request <= next_send_request;
      auto_remote_reply_enable <= next_auto_remote_reply_enable;
      abort_pending <= next_abort_pending;
    end
  end

  assign ctl_byte = {buffer_direction_select, message_aborted_flag,
                     arbitration_lost_flag, transmit_bus_error_flag,
                     send_request, auto_remote_reply_enable, 2'b00};
  // Only a transmit buffer may reach the bus
  assign tx.transmit_request = send_request &
                               buffer_direction_select;  // see R2
  assign tx.abort_request = abort_pending;
  assign tx.receive_mode = ~buffer_direction_select;  // see R2

endmodule

// ---- hw/cbt_buffer_pair_tx_control.sv ----
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// R1: Upper byte buffer n, lower byte buffer m
// R2: Direction bit selects transmit or receive
// R3: Aborted flag set on abort, clear on success
// R4: Lost-arbitration flag set when arbitration lost
// R5: Bus-error flag set on error during send
// R6: Writing one to request starts a send
// R7: Request clears itself after successful send
// R8: Writing zero while pending requests abort
// R9: Remote frame sets request when enabled
// R10: Remote frame ignored when auto reply off
// R11: New request clears the three status flags
module cbt_buffer_pair_tx_control
  import cbt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [CBT_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [CBT_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [CBT_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [CBT_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cbt_event_type [CBT_NUM_BUF-1:0] engine_event,
  output cbt_tx_type [CBT_NUM_BUF-1:0] tx
);

  function automatic logic is_ctrl_addr(input logic [CBT_ADDR_W-1:0] a);
    is_ctrl_addr = (a[CBT_ADDR_W-1:CBT_WORD_LSB] ==
                    CBT_CTRL_OFFSET[CBT_ADDR_W-1:CBT_WORD_LSB]);
  endfunction

  // Write channel state
  logic aw_held, next_aw_held;
  logic w_held, next_w_held;
  logic [CBT_ADDR_W-1:0] aw_addr_q, next_aw_addr_q;
  logic [CBT_DATA_W-1:0] w_data_q, next_w_data_q;
  logic [3:0] w_strb_q, next_w_strb_q;
  logic bvalid, next_bvalid;
  logic [1:0] bresp, next_bresp;
  logic do_write;
  logic [CBT_NUM_BUF-1:0] byte_wr;
  logic [CBT_NUM_BUF-1:0][7:0] byte_data;

  // Read channel state
  logic rvalid, next_rvalid;
  logic [1:0] rresp, next_rresp;
  logic [CBT_DATA_W-1:0] rdata, next_rdata;

  logic [CBT_NUM_BUF-1:0][7:0] ctl_byte;

  // Address and data are taken independently, in either order
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign do_write = aw_held & w_held & ~bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr_q = aw_addr_q;
    next_w_data_q = w_data_q;
    next_w_strb_q = w_strb_q;
    next_bvalid = bvalid;
    next_bresp = bresp;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data_q = s_axi_wdata;
      next_w_strb_q = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_ctrl_addr(aw_addr_q) ? CBT_RESP_OKAY :
                   CBT_RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= CBT_RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr_q <= next_aw_addr_q;
      w_data_q <= next_w_data_q;
      w_strb_q <= next_w_strb_q;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // One outstanding read; a new address waits until the data is taken
  assign s_axi_arready = ~rvalid;

  always_comb begin
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      if (is_ctrl_addr(s_axi_araddr)) begin
        next_rresp = CBT_RESP_OKAY;
        next_rdata = {CBT_UPPER_ZERO, ctl_byte[CBT_BUF_N],
                      ctl_byte[CBT_BUF_M]};  // see R1
      end else begin
        next_rresp = CBT_RESP_SLVERR;
        next_rdata = CBT_RDATA_RESET;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rresp <= CBT_RESP_OKAY;
      rdata <= CBT_RDATA_RESET;
    end else begin
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
    end
  end

  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;

  // Both buffers share one layout; byte lane i steers buffer i
  for (genvar i = 0; i < CBT_NUM_BUF; i++) begin : g_buf
    assign byte_wr[i] = do_write & is_ctrl_addr(aw_addr_q) &
                        w_strb_q[i];  // see R1
    assign byte_data[i] = w_data_q[CBT_BYTE_W*i +: CBT_BYTE_W];

    cbt_buffer_ctl u_ctl (
      .aclk(aclk),
      .aresetn(aresetn),
      .wr_en(byte_wr[i]),
      .wr_data(byte_data[i]),
      .engine_event(engine_event[i]),
      .ctl_byte(ctl_byte[i]),
      .tx(tx[i])
    );
  end

  sequence s_write_ready;
    aw_held && w_held && !bvalid;
  endsequence

  sequence s_read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_ready |=> bvalid)
    else $error("write response did not follow both channels");

  // Unmapped writes are refused with an error code, never silently
  a_slverr_write: assert property (@(posedge aclk) disable iff (!aresetn)
    s_write_ready ##0 !is_ctrl_addr(aw_addr_q) |=> bresp == CBT_RESP_SLVERR)
    else $error("unmapped write not refused");

  a_resp_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !s_axi_bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before bready");

  a_read_resp: assert property (@(posedge aclk) disable iff (!aresetn)
    s_read_taken |=> rvalid)
    else $error("read data did not follow the address");

  a_rdata_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid && !s_axi_rready |=> rvalid && $stable(s_axi_rdata) &&
    $stable(rresp))
    else $error("read data changed before rready");

  a_byte_layout: assert property ( // see R1
    @(posedge aclk) disable iff (!aresetn)
    s_read_taken ##0 is_ctrl_addr(s_axi_araddr) |=>
    rdata == {CBT_UPPER_ZERO, $past(ctl_byte[CBT_BUF_N]),
              $past(ctl_byte[CBT_BUF_M])})
    else $error("control bytes not in their lanes");

  for (genvar i = 0; i < CBT_NUM_BUF; i++) begin : g_chk
    logic req, rtren, dir, fin;
    assign req = ctl_byte[i][CBT_BIT_REQ];
    assign rtren = ctl_byte[i][CBT_BIT_RTREN];
    assign dir = ctl_byte[i][CBT_BIT_DIR];
    assign fin = engine_event[i].tx_done | engine_event[i].tx_aborted;

    sequence s_sw_send;
      byte_wr[i] && byte_data[i][CBT_BIT_REQ] && !req;
    endsequence

    sequence s_fresh_attempt;
      req && !ctl_byte[i][CBT_BIT_ABT] && !ctl_byte[i][CBT_BIT_LARB] &&
      !ctl_byte[i][CBT_BIT_ERR];
    endsequence

    a_dir_gate: assert property ( // see R2
      @(posedge aclk) disable iff (!aresetn)
      tx[i].transmit_request == (req && dir) &&
      tx[i].receive_mode == !dir)
      else $error("direction does not gate the send");

    a_abort_flag: assert property ( // see R3
      @(posedge aclk) disable iff (!aresetn)
      req && engine_event[i].tx_aborted |=>
      ctl_byte[i][CBT_BIT_ABT] && !req)
      else $error("abort not reported");

    a_abt_quiet: assert property ( // see R3
      @(posedge aclk) disable iff (!aresetn)
      !ctl_byte[i][CBT_BIT_ABT] && !engine_event[i].tx_aborted |=>
      !ctl_byte[i][CBT_BIT_ABT])
      else $error("abort flag set without cause");

    a_arb_flag: assert property ( // see R4
      @(posedge aclk) disable iff (!aresetn)
      req && engine_event[i].arb_lost |=> ctl_byte[i][CBT_BIT_LARB])
      else $error("lost arbitration not reported");

    a_arb_quiet: assert property ( // see R4
      @(posedge aclk) disable iff (!aresetn)
      !ctl_byte[i][CBT_BIT_LARB] && !engine_event[i].arb_lost |=>
      !ctl_byte[i][CBT_BIT_LARB])
      else $error("lost arbitration flag set without cause");

    a_err_flag: assert property ( // see R5
      @(posedge aclk) disable iff (!aresetn)
      req && engine_event[i].bus_error |=> ctl_byte[i][CBT_BIT_ERR])
      else $error("bus error not reported");

    a_err_quiet: assert property ( // see R5
      @(posedge aclk) disable iff (!aresetn)
      !ctl_byte[i][CBT_BIT_ERR] && !engine_event[i].bus_error |=>
      !ctl_byte[i][CBT_BIT_ERR])
      else $error("bus error flag set without cause");

    a_sw_send: assert property ( // see R6 see R11
      @(posedge aclk) disable iff (!aresetn)
      s_sw_send |=> s_fresh_attempt)
      else $error("send request not started cleanly");

    a_req_idle: assert property ( // see R6
      @(posedge aclk) disable iff (!aresetn)
      !req && !byte_wr[i] && !engine_event[i].rtr_received |=> !req)
      else $error("request set with no write or remote frame");

    a_done_clears: assert property ( // see R7
      @(posedge aclk) disable iff (!aresetn)
      req && engine_event[i].tx_done |=>
      !req && !ctl_byte[i][CBT_BIT_ABT])
      else $error("request not cleared after success");

    a_sw_abort: assert property ( // see R8
      @(posedge aclk) disable iff (!aresetn)
      byte_wr[i] && !byte_data[i][CBT_BIT_REQ] && req && !fin |=>
      tx[i].abort_request && req)
      else $error("abort request not raised");

    a_abort_holds: assert property ( // see R8
      @(posedge aclk) disable iff (!aresetn)
      tx[i].abort_request && !fin |=> tx[i].abort_request)
      else $error("abort request dropped early");

    a_rtr_sets: assert property ( // see R9 see R11
      @(posedge aclk) disable iff (!aresetn)
      engine_event[i].rtr_received && rtren && !req |=> s_fresh_attempt)
      else $error("remote frame did not set the request");

    a_rtr_ignored: assert property ( // see R10
      @(posedge aclk) disable iff (!aresetn)
      engine_event[i].rtr_received && !rtren && !byte_wr[i] &&
      !(req && fin) |=> $stable(req))
      else $error("remote frame changed the request");
  end

endmodule

// ---- testbench/cbt_engine_model.sv ----
`timescale 1ns/1ps
module cbt_engine_model
  import cbt_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire cbt_tx_type [CBT_NUM_BUF-1:0] tx,
  input wire logic [3:0] delay,
  input wire cbt_event_type [CBT_NUM_BUF-1:0] inj,
  output cbt_event_type [CBT_NUM_BUF-1:0] engine_event
);
  // Frame time shrunk to a few cycles; a slow delay leaves room for the
  // bench to land an abort or a fault while the frame is still on the bus
  logic [3:0] cnt [CBT_NUM_BUF];
  logic [3:0] next_cnt [CBT_NUM_BUF];
  cbt_event_type [CBT_NUM_BUF-1:0] fin;
  always_comb begin
    for (int b = 0; b < CBT_NUM_BUF; b++) begin
      fin[b] = '0;
      next_cnt[b] = cnt[b] + 4'h1;
      if (tx[b].abort_request && cnt[b] == delay) begin
        fin[b].tx_aborted = 1'b1;
      end else if (tx[b].transmit_request && cnt[b] == delay) begin
        fin[b].tx_done = 1'b1;
      end
      if (fin[b] != '0) begin
        next_cnt[b] = 4'h0;
      end
      if (!(tx[b].transmit_request || tx[b].abort_request)) begin
        next_cnt[b] = 4'h0;
      end
    end
  end
  always_ff @(posedge aclk) begin
    for (int b = 0; b < CBT_NUM_BUF; b++) begin
      cnt[b] <= aresetn ? next_cnt[b] : 4'h0;
    end
  end
  // Faults and remote frames come only when the bench injects them
  assign engine_event = fin | inj;
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top
  import cbt_pkg::*;
;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb, delay, ws;
  logic [1:0] bresp, rresp, r;
  cbt_event_type [CBT_NUM_BUF-1:0] ev, inj;
  cbt_tx_type [CBT_NUM_BUF-1:0] tx;
  int errors, n_checks, seed;
  int e[2];
  cbt_buffer_pair_tx_control cbt_buffer_pair_tx_control_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .engine_event(ev), .tx(tx));
  cbt_engine_model cbt_engine_model_i (.aclk(aclk), .aresetn(aresetn),
    .tx(tx), .delay(delay), .inj(inj), .engine_event(ev));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // Both channels are offered together and each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s);
    logic ah, wh, bh;
    awaddr <= a; awvalid <= 1'b1; wdata <= v; wstrb <= s;
    wvalid <= 1'b1; bready <= 1'b1; bh = 1'b0;
    // Only the watchdog ends a wait; bready stays up between writes
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready; wh = wvalid && wready;
      bh = bvalid; r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a);
    logic ah, h;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1; h = 1'b0;
    while (!h) begin
      @(negedge aclk);
      ah = arvalid && arready; h = rvalid; d = rdata; r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
    end
  endtask
  task automatic check_reg;
    rd(CBT_CTRL_OFFSET);
    chk(d, {16'h0000, e[1][7:0], e[0][7:0]});
    chk({30'h0, r}, {30'h0, CBT_RESP_OKAY});
  endtask
  task automatic pulse(input int b, input logic [4:0] v);
    inj[b] <= v;
    @(posedge aclk);
    inj[b] <= '0;
    @(posedge aclk);
  endtask
  task automatic wt(input int b);
    @(negedge aclk);
    while (tx[b].transmit_request !== 1'b0 ||
           tx[b].abort_request !== 1'b0) begin
      @(negedge aclk);
    end
    @(posedge aclk);
  endtask
  initial begin
    #(50 * 5000);
    errors++;
    summarize;
  end
  initial begin
    seed = 93037; errors = 0; n_checks = 0; aresetn = 1'b0; e = '{0, 0};
    awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
    awaddr = 0; araddr = 0; wdata = 0; wstrb = 0; delay = 4'h2; inj = '0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    check_reg;
    chk({26'h0, tx}, 32'h09);
    $display("test reset done");
    repeat (6) begin
      d = $random(seed) & 32'hffff_f7f7;
      ws = 4'($random(seed));
      wr(CBT_CTRL_OFFSET, d, ws);
      for (int b = 0; b < 2; b++) if (ws[b]) e[b] = d[8*b+:8] & 8'h84;
      check_reg;
      chk({tx[1].receive_mode, tx[0].receive_mode},
          {~e[1][7], ~e[0][7]});
    end
    wr(8'h10, 32'hffff_ffff, 4'hf);
    chk({30'h0, r}, {30'h0, CBT_RESP_SLVERR});
    rd(8'h10);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, CBT_RESP_SLVERR});
    check_reg;
    $display("test config done");
    // Direction and request land in one write: request edge sees old 0
    delay <= 4'h2 + 4'($random(seed) & 3);
    wr(CBT_CTRL_OFFSET, 32'h0000_8088, 4'h3);
    e = '{8'h88, 8'h80};
    chk(tx[0].transmit_request, 1'b1);
    wt(0);
    e[0] = 8'h80;
    check_reg;
    $display("test send done");
    delay <= 4'hf;
    wr(CBT_CTRL_OFFSET, 32'h0000_8888, 4'h3);
    wr(CBT_CTRL_OFFSET, 32'h0000_8000, 4'h2);
    chk(tx[1].abort_request, 1'b1);
    wt(0);
    wt(1);
    e = '{8'h80, 8'hc0};
    check_reg;
    $display("test abort done");
    wr(CBT_CTRL_OFFSET, 32'h0000_8888, 4'h3);
    pulse(0, 5'h04);
    pulse(0, 5'h02);
    e = '{8'hb8, 8'h88};
    check_reg;
    wt(0);
    wt(1);
    e = '{8'hb0, 8'h80};
    check_reg;
    wr(CBT_CTRL_OFFSET, 32'h0000_0088, 4'h1);
    e[0] = 8'h88;
    check_reg;
    wt(0);
    $display("test faults done");
    wr(CBT_CTRL_OFFSET, 32'h0000_8480, 4'h3);
    pulse(1, 5'h01);
    pulse(0, 5'h01);
    e = '{8'h80, 8'h8c};
    check_reg;
    wt(1);
    e[1] = 8'h84;
    check_reg;
    $display("test remote done");
    summarize;
  end
endmodule
